// ### rtl/radio_frame_buffer.sv
// frame store between the host port and the radio baseband
//
// Functional notes
// (R01) 128-byte memory, host port and baseband port work independently.
// (R02) addresses 0x00..0x7F hold one frame of maximum length.
// (R03) host/baseband access conflicts raise the underrun interrupt.
// (R04) host frame write beyond 127 octets raises underrun; content undefined.
// (R05) access only when powered (not sleep) and master clock is running.
// (R06) content changes only by host write, reception, sleep or reset.
// (R07) new frame during host frame read raises underrun, may overwrite.
// (R08) host enters locked idle to protect a received frame.
// (R09) while auto-retry waits for acknowledge, received bytes are not stored.
// (R10) other state changes keep content; sleep discards everything. Here sleep only blanks host reads; transmit still reads the old bytes.
// (R11) store length, payload, then quality, energy, status; read them after.
// (R12) random-access read returns the length byte at address 0.
// (R13) auto checksum replaces the last payload field on transmit.
// (R14) frames as short as length byte plus one data byte work.
// (R15) host and baseband ports each keep their own address counter.
// (R16) conflicts in random-access mode never raise underrun; a receive fifo drop still raises it here in any mode.
// (R17) host delays first read after reception start by 8 or 2 symbols.
// (R18) continuous host read during reception stays slower than radio rate.
// (R19) host loads transmit data faster than the radio sends it.
// (R20) underrun becomes valid two octets after reception start.
// (R21) host may still recover an overwritten frame and checks the checksum.
// (R22) host read overtaking the receive write address is a conflict.
`include "radio_frame_buffer_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module radio_frame_buffer (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        sleep_state,
    input  wire logic        master_clock_ok,
    input  wire logic        receiving_state,
    input  wire logic        auto_retry_wait,
    input  wire logic        auto_crc_on,
    input  wire logic        host_start,
    input  wire logic        host_req,
    input  wire logic        host_we,
    input  wire logic        host_mode,
    input  wire logic [6:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    output logic             host_rvalid,
    input  wire logic        rx_link_clk,
    input  wire logic        rx_link_frame,
    input  wire logic [7:0]  rx_link_data,
    output logic             rx_link_ready,
    input  wire logic        tx_start,
    input  wire logic        tx_req,
    input  wire logic [15:0] tx_fcs,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    output logic             buffer_underrun_irq
);
    radio_frame_buffer_pkg::byte_t mem [`RFB_DEPTH];      // (R01)
    radio_frame_buffer_pkg::byte_t trail_q [`RFB_TRAILER];

    // link inputs cross through two flops
    logic [1:0] lclk_s;
    logic [1:0] lfrm_s;
    logic [7:0] ldat_m;
    logic [7:0] ldat_q;
    logic       lclk_d1;
    logic       lfrm_d1;

    logic       powered;
    logic       valid_q;
    logic       link_edge;
    logic       frame_rise;
    logic       frame_fall;

    radio_frame_buffer_pkg::access_mode_t hmode_q;
    logic [7:0] hidx_q;
    logic       hrd_act_q;
    logic       hwr_act_q;
    logic       host_acc;
    logic       host_wr;
    logic [6:0] host_wa;

    radio_frame_buffer_pkg::rx_state_t rx_st_q;
    logic [7:0] ridx_q;
    logic [6:0] rlen_q;
    logic       ur_pend_q;
    logic       drain_ok;

    logic [7:0] tidx_q;
    logic [6:0] tlen_q;
    logic       tx_act_q;

    logic       ev_overflow;
    logic       ev_overtake;
    logic       ev_tx_conflict;
    logic       ev_late_start;
    logic       ev_fifo_drop;

    byte_stream_if #(.WIDTH(`RFB_BYTE_W)) fill_s ();
    byte_stream_if #(.WIDTH(`RFB_BYTE_W)) drain_s ();

    // byte of a frame seen through a frame-mode counter
    function automatic radio_frame_buffer_pkg::byte_t frame_byte(
        input logic [7:0] idx,
        input logic [6:0] len
    );
        logic [7:0] t;
        t = idx - {1'b0, len} - 8'h01;
        if (idx <= {1'b0, len}) begin
            frame_byte = mem[idx[6:0]];
        end else if (t < 8'(`RFB_TRAILER)) begin
            frame_byte = trail_q[t[1:0]];                   // (R11)
        end else begin
            frame_byte = 8'h00;
        end
    endfunction

    assign powered = !sleep_state && master_clock_ok;      // (R05)
    assign link_edge  = lclk_s[1] && !lclk_d1;
    assign frame_rise = lfrm_s[1] && !lfrm_d1;
    assign frame_fall = !lfrm_s[1] && lfrm_d1;
    assign host_acc = host_req && powered;
    assign host_wr  = host_acc && host_we;
    assign host_wa  = (hmode_q == radio_frame_buffer_pkg::ACC_SRAM) // (R02)
                    ? host_addr : hidx_q[6:0];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lclk_s  <= 2'h0;
            lfrm_s  <= 2'h0;
            ldat_m  <= 8'h00;
            ldat_q  <= 8'h00;
            lclk_d1 <= 1'b0;
            lfrm_d1 <= 1'b0;
        end else if (clk_en) begin
            lclk_s  <= {lclk_s[0], rx_link_clk};
            lfrm_s  <= {lfrm_s[0], rx_link_frame};
            ldat_m  <= rx_link_data;
            ldat_q  <= ldat_m;
            lclk_d1 <= lclk_s[1];
            lfrm_d1 <= lfrm_s[1];
        end
    end

    // link bytes enter the fifo on each rising link clock in a frame
    assign fill_s.valid = link_edge && lfrm_s[1];
    assign fill_s.data  = ldat_q;
    assign ev_fifo_drop = fill_s.valid && !fill_s.ready;

    // host writes take the memory; the drain stalls for that cycle
    assign drain_ok = !host_wr && powered;
    assign drain_s.ready = drain_ok;

    byte_fifo #(
        .WIDTH(`RFB_BYTE_W),
        .DEPTH(`RFB_FIFO_DEPTH)
    ) rx_fifo (
        .clock  (clock),
        .reset_n(reset_n),
        .clk_en (clk_en),
        .flush  (sleep_state),
        .in_s   (fill_s),
        .out_s  (drain_s)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_link_ready <= 1'b0;
        end else if (clk_en) begin
            rx_link_ready <= fill_s.ready && powered;
        end
    end

    // single write process: host first, then receive drain
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (host_wr) begin                              // (R06)
                mem[host_wa] <= host_wdata;
            end else if (drain_s.valid && drain_ok
                         && rx_st_q == radio_frame_buffer_pkg::RX_STORE
                         && ridx_q <= {1'b0, rlen_q}) begin
                mem[ridx_q[6:0]] <= drain_s.data;           // (R07)
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            trail_q[0] <= 8'h00;
            trail_q[1] <= 8'h00;
            trail_q[2] <= 8'h00;
        end else if (clk_en && drain_s.valid && drain_ok
                     && rx_st_q == radio_frame_buffer_pkg::RX_STORE
                     && ridx_q > {1'b0, rlen_q}
                     && ridx_q <= {1'b0, rlen_q} + 8'(`RFB_TRAILER)) begin
            trail_q[2'(ridx_q - {1'b0, rlen_q} - 8'h01)] <= drain_s.data;
        end
    end

    // content is lost to host reads in sleep and at reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            valid_q <= 1'b0;
        end else if (clk_en) begin
            if (sleep_state) begin
                valid_q <= 1'b0;                            // (R10)
            end else if (host_wr || (drain_s.valid && drain_ok
                         && rx_st_q == radio_frame_buffer_pkg::RX_STORE)) begin
                valid_q <= 1'b1;
            end
        end
    end

    // receive writer with its own counter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_q <= radio_frame_buffer_pkg::RX_IDLE;
            ridx_q  <= 8'h00;
            rlen_q  <= 7'h00;
        end else if (clk_en) begin
            if (sleep_state) begin
                rx_st_q <= radio_frame_buffer_pkg::RX_IDLE;
                ridx_q  <= 8'h00;
            end else begin
                case (rx_st_q)
                    radio_frame_buffer_pkg::RX_IDLE: begin
                        if (frame_rise) begin
                            ridx_q <= 8'h00;                // (R15)
                            if (receiving_state && !auto_retry_wait) begin
                                rx_st_q <= radio_frame_buffer_pkg::RX_STORE;
                            end else begin
                                rx_st_q <= radio_frame_buffer_pkg::RX_DROP;
                            end
                        end
                    end
                    radio_frame_buffer_pkg::RX_STORE: begin
                        if (drain_s.valid && drain_ok) begin
                            if (ridx_q == 8'h00) begin
                                rlen_q <= drain_s.data[6:0];    // (R14)
                            end
                            if (ridx_q != 8'hFF) begin
                                ridx_q <= ridx_q + 8'h01;
                            end
                        end else if (!lfrm_s[1] && !drain_s.valid) begin
                            rx_st_q <= radio_frame_buffer_pkg::RX_IDLE;
                        end
                    end
                    radio_frame_buffer_pkg::RX_DROP: begin
                        // evaluated elsewhere, never stored
                        if (frame_fall) begin               // (R09)
                            rx_st_q <= radio_frame_buffer_pkg::RX_IDLE;
                        end
                    end
                    default: begin
                        rx_st_q <= radio_frame_buffer_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    // host port counter and mode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hmode_q   <= radio_frame_buffer_pkg::ACC_FRAME;
            hidx_q    <= 8'h00;
            hrd_act_q <= 1'b0;
            hwr_act_q <= 1'b0;
        end else if (clk_en) begin
            if (!powered) begin
                hidx_q    <= 8'h00;
                hrd_act_q <= 1'b0;
                hwr_act_q <= 1'b0;
            end else if (host_start) begin
                hmode_q   <= host_mode
                           ? radio_frame_buffer_pkg::ACC_SRAM
                           : radio_frame_buffer_pkg::ACC_FRAME;
                hidx_q    <= 8'h00;                         // (R15)
                hrd_act_q <= !host_mode && !host_we;
                hwr_act_q <= !host_mode && host_we;
            end else if (host_acc
                         && hmode_q == radio_frame_buffer_pkg::ACC_FRAME
                         && hidx_q != 8'hFF) begin
                hidx_q <= hidx_q + 8'h01;
            end
        end
    end

    // host read data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata  <= 8'h00;
            host_rvalid <= 1'b0;
        end else if (clk_en) begin
            host_rvalid <= host_acc && !host_we;
            if (host_acc && !host_we) begin
                if (!valid_q) begin
                    host_rdata <= 8'h00;
                end else if (hmode_q == radio_frame_buffer_pkg::ACC_SRAM) begin
                    host_rdata <= mem[host_addr];           // (R12)
                end else begin
                    host_rdata <= frame_byte(hidx_q, mem[0][6:0]);
                end
            end
        end
    end

    // transmit reader with its own counter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tidx_q   <= 8'h00;
            tlen_q   <= 7'h00;
            tx_act_q <= 1'b0;
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
        end else if (clk_en) begin
            tx_valid <= tx_req && tx_act_q && powered;
            if (!powered) begin
                tx_act_q <= 1'b0;
            end else if (tx_start) begin
                tidx_q   <= 8'h00;                          // (R15)
                tlen_q   <= mem[0][6:0];
                tx_act_q <= 1'b1;
            end else if (tx_req && tx_act_q) begin
                if (auto_crc_on && tlen_q > 7'h01
                    && tidx_q == {1'b0, tlen_q} - 8'h01) begin
                    tx_data <= tx_fcs[7:0];                 // (R13)
                end else if (auto_crc_on && tlen_q > 7'h01
                             && tidx_q == {1'b0, tlen_q}) begin
                    tx_data <= tx_fcs[15:8];                // (R13)
                end else begin
                    tx_data <= mem[tidx_q[6:0]];
                end
                if (tidx_q >= {1'b0, tlen_q}) begin
                    tx_act_q <= 1'b0;
                end
                tidx_q <= tidx_q + 8'h01;
            end
        end
    end

    // conflict events, all frame mode only
    assign ev_overflow = host_wr && hwr_act_q
                      && (hidx_q > 8'(`RFB_MAX_PSDU)
                          || (hidx_q == 8'h00
                              && host_wdata > `RFB_MAX_PSDU)); // (R04)
    assign ev_overtake = host_acc && !host_we && hrd_act_q
                      && rx_st_q == radio_frame_buffer_pkg::RX_STORE
                      && ridx_q >= `RFB_UR_DELAY
                      && hidx_q >= ridx_q;                  // (R22)
    assign ev_tx_conflict = tx_req && tx_act_q && hwr_act_q
                         && tidx_q >= hidx_q;               // (R03)
    assign ev_late_start = ur_pend_q
                        && ridx_q >= `RFB_UR_DELAY;         // (R20)

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ur_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (frame_rise && hrd_act_q && receiving_state
                && !auto_retry_wait) begin
                ur_pend_q <= 1'b1;                          // (R07)
            end else if (ev_late_start || sleep_state) begin
                ur_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            buffer_underrun_irq <= 1'b0;
        end else if (clk_en) begin
            // random-access mode never sets the active flags
            buffer_underrun_irq <= ev_overflow || ev_overtake  // (R16)
                                || ev_tx_conflict || ev_late_start
                                || ev_fifo_drop;            // (R03)
        end
    end
endmodule
`default_nettype wire

// ### pkg/radio_frame_buffer_regs.svh
// constants for the radio frame buffer
`ifndef RADIO_FRAME_BUFFER_REGS_SVH
`define RADIO_FRAME_BUFFER_REGS_SVH
`define RFB_DEPTH      128
`define RFB_LAST_ADDR  7'h7F
`define RFB_MAX_PSDU   8'h7F
`define RFB_TRAILER    3
`define RFB_UR_DELAY   8'h02
`define RFB_FIFO_DEPTH 4
`define RFB_BYTE_W     8
`endif

// ### pkg/radio_frame_buffer_pkg.sv
// types shared by the radio frame buffer
package radio_frame_buffer_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic {ACC_FRAME, ACC_SRAM} access_mode_t;
    typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_DROP} rx_state_t;
endpackage

// ### pkg/byte_stream_if.sv
// valid/ready byte stream between buffer stages
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic     clock,
    input  wire logic     reset_n,
    input  wire logic     clk_en,
    input  wire logic     flush,
    byte_stream_if.snk    in_s,
    byte_stream_if.src    out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_s.ready  = (count_q != (AW+1)'(DEPTH));
    assign out_s.valid = (count_q != '0);
    assign out_s.data  = store[rd_q];
    assign push = in_s.valid && in_s.ready;
    assign pop  = out_s.valid && out_s.ready;

    always_ff @(posedge clock) begin
        if (clk_en && push) begin
            store[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else if (clk_en) begin
            if (flush) begin
                wr_q    <= '0;
                rd_q    <= '0;
                count_q <= '0;
            end else begin
                if (push) begin
                    wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
                end
                if (pop) begin
                    rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
                end
                count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/rx_link_model.sv
// behavioural radio baseband sending frames over the byte link
`timescale 1ns/100ps
`default_nettype none
module rx_link_model (
    output logic       link_clk,
    output logic       link_frame,
    output logic [7:0] link_data
);
    initial {link_clk, link_frame, link_data} = {1'b0, 1'b0, 8'hFF};
    // length, payload, three trailer bytes; gap slows the far side
    task automatic send(input logic [6:0] len, input logic [7:0] base,
                        input int gap);
        #3 link_frame = 1'b1;
        for (int k = 0; k <= len + 3; k++) begin
            link_data = (k == 0) ? {1'b0, len} : base + 8'(k);
            #(80 + gap) link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        link_frame = 1'b0;
        link_data = ~link_data;
    endtask
endmodule
`default_nettype wire

// ### tb/radio_frame_buffer_monitor.sv
// concurrent checks on the radio frame buffer ports
`timescale 1ns/100ps
`default_nettype none
module radio_frame_buffer_monitor (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire logic       sleep_state,
    input wire logic       master_clock_ok,
    input wire logic       host_req,
    input wire logic       host_we,
    input wire logic       host_rvalid,
    input wire logic [7:0] host_rdata,
    input wire logic       tx_req,
    input wire logic       tx_valid,
    input wire logic       rx_link_ready,
    input wire logic       buffer_underrun_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_READ_ANSWER:
        assert property (host_req && !host_we && clk_en && master_clock_ok
            && !sleep_state |=> host_rvalid)
        else $error("read not answered");
    AST_ANSWER_CAUSE:
        assert property (host_rvalid && $past(clk_en)
            |-> $past(host_req) && !$past(host_we))
        else $error("read answer without request");
    AST_TX_CAUSE:
        assert property (tx_valid |-> $past(tx_req) && $past(clk_en))
        else $error("transmit byte without request");
    AST_ASLEEP:
        assert property (host_req && (sleep_state || !master_clock_ok)
            |=> !host_rvalid)
        else $error("read answered while unpowered");
    AST_READY_OFF:
        assert property (sleep_state [*2] |-> !rx_link_ready)
        else $error("link ready while asleep");
    AST_FREEZE:
        assert property (!clk_en |=> $stable(host_rdata)
            && $stable(host_rvalid) && $stable(buffer_underrun_irq))
        else $error("outputs moved while frozen");
    AST_UR_PULSE:
        assert property (buffer_underrun_irq |=> !buffer_underrun_irq)
        else $error("underrun longer than one cycle");
    AST_RST_QUIET:
        assert property ($rose(reset_n) |-> !host_rvalid && !tx_valid
            && !buffer_underrun_irq)
        else $error("output active at reset release");
endmodule
bind radio_frame_buffer radio_frame_buffer_monitor u_mon (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .sleep_state(sleep_state), .master_clock_ok(master_clock_ok),
    .host_req(host_req), .host_we(host_we), .host_rvalid(host_rvalid),
    .host_rdata(host_rdata), .tx_req(tx_req), .tx_valid(tx_valid),
    .rx_link_ready(rx_link_ready),
    .buffer_underrun_irq(buffer_underrun_irq)
);
`default_nettype wire

// ### tb/testbench.sv
// self-checking testbench for the radio frame buffer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clock, reset_n, clk_en, sleep_state, master_clock_ok;
    logic        receiving_state, auto_retry_wait, auto_crc_on, tx_start;
    logic        host_start, host_req, host_we, host_mode, tx_req;
    logic        host_rvalid, rx_link_ready, tx_valid, ur_irq, got_v;
    logic        lk_clk, lk_frame;
    logic [6:0]  host_addr;
    logic [7:0]  host_wdata, host_rdata, tx_data, lk_data, got_d;
    logic [15:0] tx_fcs;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          ur_n = 0;
    rx_link_model u_link (.link_clk(lk_clk), .link_frame(lk_frame),
                          .link_data(lk_data));
    radio_frame_buffer u_dut (
        .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .sleep_state(sleep_state), .master_clock_ok(master_clock_ok),
        .receiving_state(receiving_state),
        .auto_retry_wait(auto_retry_wait), .auto_crc_on(auto_crc_on),
        .host_start(host_start), .host_req(host_req), .host_we(host_we),
        .host_mode(host_mode), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .rx_link_clk(lk_clk),
        .rx_link_frame(lk_frame), .rx_link_data(lk_data),
        .rx_link_ready(rx_link_ready), .tx_start(tx_start),
        .tx_req(tx_req), .tx_fcs(tx_fcs), .tx_data(tx_data),
        .tx_valid(tx_valid), .buffer_underrun_irq(ur_irq)
    );
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        if (ur_irq === 1'b1) ur_n++;
    end
    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic hbeg(input logic m, input logic w);
        @(negedge clock) {host_start, host_mode, host_we} = {1'b1, m, w};
        @(negedge clock) host_start = 1'b0;
    endtask
    task automatic hwr(input logic [6:0] a, input logic [7:0] b);
        @(negedge clock) {host_req, host_addr, host_wdata} = {1'b1, a, b};
        @(negedge clock) host_req = 1'b0;
    endtask
    task automatic hrd(input logic [6:0] a);
        @(negedge clock) {host_req, host_addr} = {1'b1, a};
        @(negedge clock) host_req = 1'b0;
        if (host_rvalid !== 1'b1) @(negedge clock);
        {got_v, got_d} = {host_rvalid, host_rdata};
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        hrd(a);
        chk("host valid", 8'h01, 8'(got_v));
        chk("host byte", e, got_d);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_tx;
        logic [7:0] e;
        int u;
        u = ur_n;
        hbeg(1'b0, 1'b1);
        hwr(7'h00, 8'h04);
        for (int k = 1; k <= 4; k++) hwr(7'h00, 8'h10 + 8'(k));
        hbeg(1'b1, 1'b0);
        for (int c = 0; c < 2; c++) begin
            @(negedge clock) {auto_crc_on, tx_start} = {c[0], 1'b1};
            @(negedge clock) tx_start = 1'b0;
            for (int k = 0; k <= 4; k++) begin
                e = (k == 0) ? 8'h04 : 8'h10 + 8'(k);
                if (c == 1 && k >= 3) e = (k == 3) ? 8'hEF : 8'hBE;
                @(negedge clock) tx_req = 1'b1;
                @(negedge clock) tx_req = 1'b0;
                if (tx_valid !== 1'b1) @(negedge clock);
                chk("tx valid", 8'h01, 8'(tx_valid));
                chk("tx byte", e, tx_data);
            end
        end
        chk("underrun count", 8'h00, 8'(ur_n - u));
        u = ur_n;
        hbeg(1'b0, 1'b1);
        @(negedge clock) tx_start = 1'b1;
        @(negedge clock) tx_start = 1'b0;
        @(negedge clock) tx_req = 1'b1;
        @(negedge clock) tx_req = 1'b0;
        repeat (2) @(negedge clock);
        chk("tx conflict underrun", 8'h01, 8'(ur_n - u));
        $display("transmit test finished");
    endtask
    task automatic t_rx;
        int u;
        u = ur_n;
        receiving_state = 1'b1;
        u_link.send(7'h03, 8'h30, 0);
        repeat (40) @(negedge clock);
        hbeg(1'b0, 1'b0);
        for (int k = 0; k < 7; k++) rd(7'h00, (k == 0) ? 8'h03 : 8'h30 + 8'(k));
        hbeg(1'b1, 1'b0);
        rd(7'h00, 8'h03);
        chk("underrun count", 8'h00, 8'(ur_n - u));
        chk("link ready", 8'h01, 8'(rx_link_ready));
        receiving_state = 1'b0;
        u_link.send(7'h02, 8'h50, 0);
        repeat (40) @(negedge clock);
        receiving_state = 1'b1;
        auto_retry_wait = 1'b1;
        u_link.send(7'h02, 8'h60, 400);
        repeat (40) @(negedge clock);
        auto_retry_wait = 1'b0;
        rd(7'h01, 8'h31);
        $display("receive test finished");
    endtask
    task automatic t_conflict;
        int u;
        u = ur_n;
        hbeg(1'b0, 1'b0);
        hrd(7'h00);
        u_link.send(7'h05, 8'h70, 0);
        repeat (40) @(negedge clock);
        chk("underrun seen", 8'h01, 8'(ur_n != u));
        hbeg(1'b1, 1'b0);
        rd(7'h00, 8'h05);
        u = ur_n;
        hbeg(1'b0, 1'b1);
        hwr(7'h00, 8'h80);
        repeat (3) @(negedge clock);
        chk("oversize underrun", 8'h01, 8'(ur_n - u));
        u = ur_n;
        fork
            u_link.send(7'h05, 8'h40, 0);
            begin
                repeat (20) @(negedge clock);
                hbeg(1'b0, 1'b0);
                repeat (6) hrd(7'h00);
            end
        join
        chk("overtake underrun", 8'h01, 8'(ur_n != u));
        $display("conflict test finished");
    endtask
    task automatic t_power;
        hbeg(1'b1, 1'b1);
        hwr(7'h7F, 8'hA5);
        hbeg(1'b1, 1'b0);
        rd(7'h7F, 8'hA5);
        @(negedge clock) clk_en = 1'b0;
        hrd(7'h7F);
        chk("frozen answer", 8'h00, 8'(got_v));
        {clk_en, master_clock_ok} = 2'h2;
        hrd(7'h7F);
        chk("no clock answer", 8'h00, 8'(got_v));
        {master_clock_ok, sleep_state} = 2'h3;
        hrd(7'h7F);
        chk("asleep answer", 8'h00, 8'(got_v));
        chk("asleep ready", 8'h00, 8'(rx_link_ready));
        sleep_state = 1'b0;
        hbeg(1'b1, 1'b0);
        rd(7'h7F, 8'h00);
        $display("power test finished");
    endtask
    initial begin
        {clk_en, master_clock_ok, sleep_state, receiving_state} = 4'hC;
        {auto_retry_wait, auto_crc_on, host_start, host_req} = 4'h0;
        {host_we, host_mode, tx_start, tx_req} = 4'h0;
        {host_addr, host_wdata, tx_fcs} = {7'h00, 8'h00, 16'hBEEF};
        reset_n = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        t_tx;
        t_rx;
        t_conflict;
        t_power;
        stop_test;
    end
    initial begin
        #300000;
        fail_count++;
        stop_test;
    end
endmodule
`default_nettype wire
